/* File: rtl/sbcs_pkg.sv */
// constants, field layout and encodings of the serial transfer clock selector
package sbcs_pkg;
    // register byte offsets
    localparam logic [7:0] ADDR_BAUD = 8'h00;
    localparam logic [7:0] ADDR_FRACK = 8'h04;
    localparam logic [7:0] ADDR_MODE = 8'h08;
    localparam logic [7:0] ADDR_CTRL = 8'h0C;
    localparam logic [7:0] ADDR_STAT = 8'h10;
    // baud_divider_control fields
    localparam int BRS_LSB = 0;
    localparam int TAP_LSB = 4;
    localparam int FRAC_EN_BIT = 6;
    // fractional_k_control field
    localparam int FRACK_LSB = 0;
    // serial_mode_control0 fields
    localparam int MODE_LSB = 0;
    localparam int SRC_LSB = 2;
    // serial_control fields
    localparam int PIN_IN_BIT = 0;
    localparam int EDGE_BIT = 1;
    // status fields
    localparam int ST_SCLK_BIT = 0;
    localparam int ST_BRG_LSB = 4;
    localparam int ST_GRP_LSB = 12;
    localparam int ST_OVS_LSB = 20;
    // reset values
    localparam logic [3:0] DIV_N_RST = 4'h0;
    localparam logic [1:0] TAP_RST = 2'h0;
    localparam logic [3:0] FRACK_RST = 4'h0;
    // uart oversampling: selected clock divided by 16 per bit
    localparam int UART_OVS = 16;
    // operating mode
    typedef enum logic [1:0] {
        MODE_IO = 2'h0,
        MODE_UART = 2'h1
    } sbcs_mode_t;
    // uart clock source
    typedef enum logic [1:0] {
        SRC_TIMER = 2'h0,
        SRC_BRG = 2'h1,
        SRC_FSYS = 2'h2,
        SRC_PIN = 2'h3
    } sbcs_src_t;
endpackage : sbcs_pkg

/* File: rtl/sbcs_top.sv */
// serial transfer clock selector: baud generator, clock pin and uart clock choice
//
// Contract
// - baud input is one of four prescaler taps /2,/8,/32,/128; code 00 is /2
// - i/o mode divides by N only; uart divides by N or fraction per enable
// - four-bit N field is the ratio; N spans 1 to 16
// - fractional uart division is N+(16-K)/16; software keeps N 2..15, K 1..15
// - i/o mode, pin output: transfer clock is baud output divided by 2
// - i/o mode, pin input: transfer on rising or falling pin edge per edge bit
// - mode field picks i/o or uart; each mode has its own clock selection
// - uart source field picks timer, baud generator, system clock or pin
// - uart counters divide the selected clock by 16 per bit
//
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/1ns
`default_nettype none
module sbcs_top #(
    parameter int DIV_W = 4
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RESETN,
    // register port
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    // clock sources: prescaler enables /2,/8,/32,/128 and timer flip-flop
    input wire logic [3:0] TAP_TICK,
    input wire logic TIMER_FF,
    // clock pin
    input wire logic SCLK_IN,
    output logic SCLK_OUT,
    output logic SCLK_OE,
    // transfer clock enables
    output logic XFER_TICK,
    output logic BIT_TICK
);
    generate
        if (DIV_W != 4) begin : g_bad_width
            $error("divisor field must be four bits wide");
        end
    endgenerate

    localparam int OVS_W = $clog2(sbcs_pkg::UART_OVS);
    localparam logic [DIV_W:0] FULL_RATIO = (DIV_W+1)'(2 ** DIV_W);
    localparam logic [OVS_W-1:0] OVS_LAST = OVS_W'(sbcs_pkg::UART_OVS - 1);

    // software fields
    logic [DIV_W-1:0] div_n;
    logic [1:0] tap_sel;
    logic frac_en;
    logic [DIV_W-1:0] frac_k;
    logic [1:0] op_mode;
    logic [1:0] clk_src;
    logic pin_in;
    logic edge_fall;
    // internal state
    logic [DIV_W:0] brg_cnt;
    logic [DIV_W-1:0] grp_cnt;
    logic [OVS_W-1:0] ovs_cnt;
    logic pin_s1;
    logic pin_s2;
    logic pin_s3;
    logic tmr_prev;
    logic [31:0] rd_mux;

    // register write decode
    wire wr_baud = WR && (ADDR == sbcs_pkg::ADDR_BAUD);
    wire wr_frack = WR && (ADDR == sbcs_pkg::ADDR_FRACK);
    wire wr_mode = WR && (ADDR == sbcs_pkg::ADDR_MODE);
    wire wr_ctrl = WR && (ADDR == sbcs_pkg::ADDR_CTRL);
    // any divider setting change restarts the baud count
    wire cfg_wr = wr_baud || wr_frack || wr_mode;

    // mode decode
    wire io_mode = (op_mode == sbcs_pkg::MODE_IO);
    wire io_out = io_mode && !pin_in;
    wire io_in = io_mode && pin_in;
    wire frac_act = !io_mode && frac_en;

    // baud generator input tap and ratio
    wire brg_in = TAP_TICK[tap_sel];
    wire [DIV_W:0] n_ratio = (div_n == '0) ? FULL_RATIO : {1'b0, div_n};
    wire [DIV_W:0] frac_lim = FULL_RATIO - {1'b0, frac_k};
    wire long_per = frac_act && ({1'b0, grp_cnt} < frac_lim);
    wire [DIV_W:0] brg_lim = long_per ? n_ratio : n_ratio - 1'b1;
    wire brg_tick = brg_in && (brg_cnt >= brg_lim);

    // clock pin edges, read only after the second stage
    wire pin_rise = pin_s2 && !pin_s3;
    wire pin_fall = !pin_s2 && pin_s3;
    // timer flip-flop toggles per match, one rising edge per two matches
    wire tmr_rise = TIMER_FF && !tmr_prev;

    // i/o transfer edge
    wire io_out_tick = io_out && brg_tick && !SCLK_OUT;
    wire io_in_tick = io_in && (edge_fall ? pin_fall : pin_rise);
    wire io_tick = io_out_tick || io_in_tick;

    // uart clock selection
    wire uart_sel = (clk_src == sbcs_pkg::SRC_TIMER) ? tmr_rise :
                    (clk_src == sbcs_pkg::SRC_BRG) ? brg_tick :
                    (clk_src == sbcs_pkg::SRC_FSYS) ? 1'b1 : pin_rise;
    wire uart_tick = !io_mode && uart_sel;
    wire ovs_wrap = uart_tick && (ovs_cnt == OVS_LAST);

    // next values
    wire next_sclk = io_out ? (SCLK_OUT ^ brg_tick) : 1'b1;
    wire next_xfer = io_mode ? io_tick : uart_tick;

    // software register file
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            div_n <= sbcs_pkg::DIV_N_RST;
            tap_sel <= sbcs_pkg::TAP_RST;
            frac_en <= 1'b0;
            frac_k <= sbcs_pkg::FRACK_RST;
            op_mode <= sbcs_pkg::MODE_IO;
            clk_src <= sbcs_pkg::SRC_TIMER;
            pin_in <= 1'b0;
            edge_fall <= 1'b0;
        end else begin
            if (wr_baud) begin
                div_n <= WDATA[sbcs_pkg::BRS_LSB +: DIV_W];
                tap_sel <= WDATA[sbcs_pkg::TAP_LSB +: 2];
                frac_en <= WDATA[sbcs_pkg::FRAC_EN_BIT];
            end
            if (wr_frack) begin
                frac_k <= WDATA[sbcs_pkg::FRACK_LSB +: DIV_W];
            end
            if (wr_mode) begin
                op_mode <= WDATA[sbcs_pkg::MODE_LSB +: 2];
                clk_src <= WDATA[sbcs_pkg::SRC_LSB +: 2];
            end
            if (wr_ctrl) begin
                pin_in <= WDATA[sbcs_pkg::PIN_IN_BIT];
                edge_fall <= WDATA[sbcs_pkg::EDGE_BIT];
            end
        end
    end

    // read decode
    always_comb begin
        rd_mux = '0;
        if (ADDR == sbcs_pkg::ADDR_BAUD) begin
            rd_mux[sbcs_pkg::BRS_LSB +: DIV_W] = div_n;
            rd_mux[sbcs_pkg::TAP_LSB +: 2] = tap_sel;
            rd_mux[sbcs_pkg::FRAC_EN_BIT] = frac_en;
        end else if (ADDR == sbcs_pkg::ADDR_FRACK) begin
            rd_mux[sbcs_pkg::FRACK_LSB +: DIV_W] = frac_k;
        end else if (ADDR == sbcs_pkg::ADDR_MODE) begin
            rd_mux[sbcs_pkg::MODE_LSB +: 2] = op_mode;
            rd_mux[sbcs_pkg::SRC_LSB +: 2] = clk_src;
        end else if (ADDR == sbcs_pkg::ADDR_CTRL) begin
            rd_mux[sbcs_pkg::PIN_IN_BIT] = pin_in;
            rd_mux[sbcs_pkg::EDGE_BIT] = edge_fall;
        end else if (ADDR == sbcs_pkg::ADDR_STAT) begin
            rd_mux[sbcs_pkg::ST_SCLK_BIT] = SCLK_OUT;
            rd_mux[sbcs_pkg::ST_BRG_LSB +: DIV_W+1] = brg_cnt;
            rd_mux[sbcs_pkg::ST_GRP_LSB +: DIV_W] = grp_cnt;
            rd_mux[sbcs_pkg::ST_OVS_LSB +: OVS_W] = ovs_cnt;
        end
    end

    // read data, one cycle after the strobe, zero otherwise
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            RDATA <= 32'h0000_0000;
        end else begin
            RDATA <= RD ? rd_mux : 32'h0000_0000;
        end
    end

    // pin synchroniser and edge history
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            pin_s1 <= 1'b0;
            pin_s2 <= 1'b0;
            pin_s3 <= 1'b0;
            tmr_prev <= 1'b0;
        end else begin
            pin_s1 <= SCLK_IN;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            tmr_prev <= TIMER_FF;
        end
    end

    // baud generator counter and fractional group
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            brg_cnt <= '0;
            grp_cnt <= '0;
        end else if (cfg_wr) begin
            brg_cnt <= '0; // a shorter limit must not leave the count past it
            grp_cnt <= '0;
        end else if (brg_in) begin
            brg_cnt <= brg_tick ? '0 : brg_cnt + 1'b1;
            if (brg_tick) begin
                grp_cnt <= frac_act ? grp_cnt + 1'b1 : '0;
            end
        end
    end

    // uart divide by 16
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            ovs_cnt <= '0;
        end else if (io_mode) begin
            ovs_cnt <= '0;
        end else if (uart_tick) begin
            ovs_cnt <= ovs_cnt + 1'b1;
        end
    end

    // outputs
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            SCLK_OUT <= 1'b1;
            SCLK_OE <= 1'b0;
            XFER_TICK <= 1'b0;
            BIT_TICK <= 1'b0;
        end else begin
            SCLK_OUT <= next_sclk;
            SCLK_OE <= io_out;
            XFER_TICK <= next_xfer;
            BIT_TICK <= ovs_wrap;
        end
    end

    // counter only moves on the selected tap or a baud, fraction or mode write
    property p_tap_gate;
        @(posedge CLK) disable iff (!RESETN)
        (!brg_in && !cfg_wr) |=> $stable(brg_cnt);
    endproperty
    a_tap_gate: assert property (p_tap_gate)
        else $error("baud counter moved without tap pulse");

    // plain N division outside fractional mode
    property p_int_div;
        @(posedge CLK) disable iff (!RESETN)
        (brg_tick && !frac_act) |-> (brg_cnt == n_ratio - 1'b1);
    endproperty
    a_int_div: assert property (p_int_div)
        else $error("integer division period wrong");

    // zero field means ratio sixteen
    property p_zero_full;
        @(posedge CLK) disable iff (!RESETN)
        (brg_tick && !frac_act && div_n == '0) |-> (brg_cnt == FULL_RATIO - 1'b1);
    endproperty
    a_zero_full: assert property (p_zero_full)
        else $error("zero divisor field not ratio sixteen");

    // long periods first in each group, short after
    property p_frac_len;
        @(posedge CLK) disable iff (!RESETN)
        (brg_tick && frac_act) |->
            (brg_cnt == (({1'b0, grp_cnt} < frac_lim) ? n_ratio : n_ratio - 1'b1));
    endproperty
    a_frac_len: assert property (p_frac_len)
        else $error("fractional period length wrong");

    // pin output toggles on every baud tick
    property p_sclk_half;
        @(posedge CLK) disable iff (!RESETN)
        (brg_tick && io_out && SCLK_OE) |=> (SCLK_OUT != $past(SCLK_OUT));
    endproperty
    a_sclk_half: assert property (p_sclk_half)
        else $error("pin clock did not toggle on baud tick");

    // transfer edge follows selected pin edge
    property p_pin_edge;
        @(posedge CLK) disable iff (!RESETN)
        (io_in && (edge_fall ? (!pin_s2 && pin_s3) : (pin_s2 && !pin_s3))) |=> XFER_TICK;
    endproperty
    a_pin_edge: assert property (p_pin_edge)
        else $error("pin edge did not give transfer tick");

    // pin driven only in i/o output mode
    property p_oe_mode;
        @(posedge CLK) disable iff (!RESETN)
        SCLK_OE |-> $past(op_mode == sbcs_pkg::MODE_IO && !pin_in);
    endproperty
    a_oe_mode: assert property (p_oe_mode)
        else $error("pin driven outside i/o output mode");

    // system clock source ticks every cycle
    property p_fsys_src;
        @(posedge CLK) disable iff (!RESETN)
        (!io_mode && clk_src == sbcs_pkg::SRC_FSYS) [*2] |=> XFER_TICK;
    endproperty
    a_fsys_src: assert property (p_fsys_src)
        else $error("system clock source missed a tick");

    // one bit tick per sixteen selected clocks
    property p_bit_div;
        @(posedge CLK) disable iff (!RESETN)
        BIT_TICK |-> ($past(ovs_cnt) == OVS_LAST && ovs_cnt == '0);
    endproperty
    a_bit_div: assert property (p_bit_div)
        else $error("bit tick not at sixteenth clock");
endmodule : sbcs_top
`default_nettype wire

/* File: dv/sbcs_peer.sv */
// serial peer model that drives the clock pin from outside
`timescale 1ns/1ns
`default_nettype none
module sbcs_peer #(
    parameter int HALF_NS = 250
) (
    // control from the bench
    input wire logic run,
    // clock pin drive
    output var logic pin_drive,
    output var logic pin_oe
);
    // pin clock runs only while enabled, then the pin is released
    initial begin
        pin_drive = 1'b1;
        pin_oe = 1'b0;
        forever begin
            @(posedge run);
            #13 pin_oe = 1'b1;
            while (run === 1'b1) begin
                #HALF_NS pin_drive = 1'b0; // period ten clocks
                #HALF_NS pin_drive = 1'b1;
            end
            pin_oe = 1'b0;
        end
    end
endmodule : sbcs_peer
`default_nettype wire

/* File: dv/tb_serial_baud_clock_select.sv */
// self-checking bench for the serial transfer clock selector
`timescale 1ns/1ns
`default_nettype none
module tb_serial_baud_clock_select;
    logic CLK, RESETN, WR, RD, SCLK_OUT, SCLK_OE, XFER_TICK, BIT_TICK;
    logic TIMER_FF = 1'b0;
    logic tap_ph = 1'b0;
    logic [2:0] tcnt = 3'h0;
    logic [7:0] ADDR;
    logic [31:0] WDATA, RDATA, d;
    logic [3:0] TAP_TICK, hist;
    logic peer_run, peer_pin, peer_oe, sclk_wire;
    logic [1:0] tap;
    int fails, n_compared, n, nd, kf;
    logic [7:0] regs [4];
    logic [31:0] msk [4];
    // pin level: device when enabled, else peer, else pull-up
    assign sclk_wire = (SCLK_OE === 1'b1) ? SCLK_OUT : (peer_oe ? peer_pin : 1'b1);
    sbcs_top #(.DIV_W(4)) u_sbcs_top (.CLK(CLK), .RESETN(RESETN), .ADDR(ADDR),
        .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .TAP_TICK(TAP_TICK),
        .TIMER_FF(TIMER_FF), .SCLK_IN(sclk_wire), .SCLK_OUT(SCLK_OUT), .SCLK_OE(SCLK_OE),
        .XFER_TICK(XFER_TICK), .BIT_TICK(BIT_TICK));
    sbcs_peer u_sbcs_peer (.run(peer_run), .pin_drive(peer_pin), .pin_oe(peer_oe));
    // system clock
    initial begin
        CLK = 1'b0;
        forever #25 CLK = ~CLK;
    end
    // tap pulses every second cycle, timer flip-flop toggles every third cycle
    always @(posedge CLK) begin
        tap_ph <= ~tap_ph; // tap no faster than half the system clock
        TAP_TICK <= tap_ph ? (4'h1 << tap) : 4'h0;
        tcnt <= (tcnt == 3'h2) ? 3'h0 : tcnt + 3'h1;
        if (tcnt == 3'h2) TIMER_FF <= ~TIMER_FF; // toggle on compare match
        hist <= {hist[2:0], sclk_wire};
    end
    task automatic close_out();
        if (fails == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_gap(input int got, input int exp);
        n_compared++;
        if (got != exp) begin
            fails++;
            $display("CHECK FAILED t=%0t gap=%h exp=%h", $time, got, exp);
        end
    endtask : chk_gap
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= v;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1 v = RDATA;
    endtask : rd
    function automatic logic hit(input logic which);
        return which ? (BIT_TICK === 1'b1) : (XFER_TICK === 1'b1);
    endfunction : hit
    // cycles between the second and third pulse seen, each wait bounded
    task automatic gap(input logic which, input int lim, output int g);
        int c;
        c = 0;
        for (int k = 0; k < 3; k++) begin
            c = 0;
            do begin
                @(posedge CLK);
                #1 c++;
            end while (!hit(which) && c < lim);
            if (!hit(which)) begin
                fails++;
                close_out();
            end
        end
        g = c;
    endtask : gap
    // main sequence
    initial begin
        RESETN = 1'b0;
        ADDR = 8'h00;
        WDATA = 32'h0000_0000;
        WR = 1'b0;
        RD = 1'b0;
        tap = 2'h0;
        peer_run = 1'b0;
        regs = '{sbcs_pkg::ADDR_BAUD, sbcs_pkg::ADDR_FRACK, sbcs_pkg::ADDR_MODE,
            sbcs_pkg::ADDR_CTRL};
        msk = '{32'h0000_007F, 32'h0000_000F, 32'h0000_000F, 32'h0000_0003};
        n = $urandom(32'h4947);
        repeat (3) @(posedge CLK);
        chk(32'({SCLK_OE, SCLK_OUT, XFER_TICK}), 32'h0000_0002); // pin idle in reset
        RESETN <= 1'b1;
        rd(sbcs_pkg::ADDR_BAUD, d);
        chk(d, 32'({sbcs_pkg::TAP_RST, sbcs_pkg::DIV_N_RST})); // reset tap and divisor
        rd(sbcs_pkg::ADDR_FRACK, d);
        chk(d, 32'(sbcs_pkg::FRACK_RST)); // reset fraction
        rd(sbcs_pkg::ADDR_STAT, d);
        chk(32'(d[sbcs_pkg::ST_SCLK_BIT]), 32'h0000_0001); // pin output idles high
        // random register values read back through their fields
        for (int i = 0; i < 4; i++) begin
            d = $urandom;
            wr(regs[i], d);
            rd(regs[i], d);
            chk(d, WDATA & msk[i]); // field widths
        end
        wr(8'h14, 32'hFFFF_FFFF);
        rd(8'h14, d);
        chk(d, 32'h0000_0000); // unmapped place reads zero
        // uart on system clock: every cycle a tick, bit every sixteen
        wr(sbcs_pkg::ADDR_MODE, 32'h0000_0009);
        gap(1'b1, 60, n);
        chk_gap(n, 16); // system clock source
        // uart on baud generator, every tap, integer then fraction
        for (int k = 0; k < 4; k++) begin
            nd = $urandom_range(2, 15);
            kf = $urandom_range(1, 15);
            tap = k[1:0];
            wr(sbcs_pkg::ADDR_MODE, 32'h0000_0005);
            wr(sbcs_pkg::ADDR_BAUD, 32'((k << sbcs_pkg::TAP_LSB) | nd));
            gap(1'b1, 64 * nd + 60, n);
            chk_gap(n, 32 * nd); // tap choice and integer ratio
            wr(sbcs_pkg::ADDR_FRACK, 32'(kf));
            wr(sbcs_pkg::ADDR_BAUD, 32'((k << sbcs_pkg::TAP_LSB) | nd | 64));
            gap(1'b1, 68 * nd + 100, n);
            chk_gap(n, 2 * (16 * nd + 16 - kf)); // fractional ratio
        end
        // i/o mode, pin output, fraction left enabled: ratio stays integer
        wr(sbcs_pkg::ADDR_MODE, 32'h0000_0000);
        wr(sbcs_pkg::ADDR_CTRL, 32'h0000_0000); // rising edge with pin output
        for (int k = 0; k < 3; k++) begin
            nd = (k == 0) ? 2 : (k == 1) ? 16 : $urandom_range(3, 15); // never one
            wr(sbcs_pkg::ADDR_BAUD, 32'((32'(tap) << sbcs_pkg::TAP_LSB) | 64 | nd % 16));
            gap(1'b0, 8 * nd + 60, n);
            chk_gap(n, 4 * nd); // baud output halved
            chk(32'({SCLK_OE, SCLK_OUT}), 32'h0000_0003); // pin driven, just risen
        end
        // i/o mode, pin input on either edge
        peer_run <= 1'b1;
        for (int e = 0; e < 2; e++) begin
            wr(sbcs_pkg::ADDR_CTRL, 32'(1 + 2 * e));
            gap(1'b0, 40, n);
            chk_gap(n, 10); // one transfer per pin period
            chk(32'(hist[1]), 32'(1 - e)); // edge polarity
            chk(32'(SCLK_OE), 32'h0000_0000); // pin released
        end
        // uart on pin, then on timer
        wr(sbcs_pkg::ADDR_MODE, 32'h0000_000D);
        gap(1'b1, 220, n);
        chk_gap(n, 160); // pin source
        wr(sbcs_pkg::ADDR_MODE, 32'h0000_0001);
        gap(1'b1, 150, n);
        chk_gap(n, 96); // timer source, rising edges
        peer_run <= 1'b0;
        close_out();
    end
endmodule : tb_serial_baud_clock_select
`default_nettype wire
